//--- bench/asr_chk.sv
// port assertions for the sample router
`default_nettype none
module asr_chk (
   input wire logic mclk, // clock
   input wire logic sys_rst, // reset
   input wire logic perRdEn, // read strobe
   input wire logic [7:0] perAddr, // address
   input wire logic [31:0] perRdData, // read word
   input wire logic perRdValid, // read valid
   input wire logic adcStart, // start pulse
   input wire logic [1:0] adcSel, // selected input
   input wire logic adcDone, // done pulse
   input wire logic [11:0] adcResult, // result
   input wire logic epValid, // offered
   input wire logic epReady, // taken
   input wire logic [23:0] epDest, // destination
   input wire logic [1:0] epPin, // pin
   input wire logic [11:0] epSample // sample
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_rd_valid: assert property (perRdEn |=> perRdValid)
      else $error("read not answered");
   a_rd_cause: assert property (perRdValid |-> $past(perRdEn))
      else $error("read valid without read");
   a_rsvd_zero: assert property (perRdValid && $past(perAddr) < 8'h10 |-> perRdData[7:1] == 7'h0)
      else $error("reserved bits not zero");
   a_start_pulse: assert property (adcStart |=> !adcStart)
      else $error("start longer than one cycle");
   a_sel_hold: assert property (!adcStart |-> $stable(adcSel))
      else $error("input changed without start");
   a_sample_out: assert property (adcDone |=> epValid && epSample == $past(adcResult)
      && epPin == $past(adcSel))
      else $error("sample not offered");
   a_ep_hold: assert property (epValid && !epReady |=> epValid && $stable(epDest)
      && $stable(epPin) && $stable(epSample))
      else $error("offer dropped");
   a_rst_quiet: assert property ($fell(sys_rst) |-> !epValid && !adcStart && perRdData == 0)
      else $error("outputs not reset");
endmodule
bind asr_sample_router asr_chk chk_u (.*);
`default_nettype wire

//--- bench/asr_partner.sv
// converter and endpoint model on the far side of the sample router
`default_nettype none
module asr_partner #(parameter int CONV = 3, parameter int STALL = 2) (
   input wire logic mclk, // clock
   input wire logic adcStart, // start pulse
   input wire logic [1:0] adcSel, // input to convert
   output logic adcDone, // done pulse
   output logic [11:0] adcResult, // result, scrambled outside done
   input wire logic epValid, // sample offered
   output logic epReady // sample taken
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0; // conversion countdown
   int wt = 0; // endpoint stall count
   initial begin
      adcDone = 0;
      adcResult = 0;
      epReady = 0;
   end
   // fixed latency converter, then a slow endpoint that stalls first
   always @(posedge mclk) begin
      adcDone <= 1'b0;
      adcResult <= ~adcResult;
      epReady <= 1'b0;
      if (cnt == 1) begin
         adcDone <= 1'b1;
         adcResult <= {adcSel, 10'h2a5};
      end
      if (cnt > 0) cnt <= cnt - 1;
      if (adcStart) cnt <= CONV;
      if (epValid && !epReady) wt <= wt + 1;
      if (epValid && !epReady && wt == STALL) begin
         epReady <= 1'b1;
         wt <= 0;
      end
   end
endmodule
`default_nettype wire

//--- bench/asr_sample_router_tb_top.sv
// testbench for the sample router
`default_nettype none
module asr_sample_router_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, sys_rst = 1, perWrEn = 0, perRdEn = 0, sampleClkPin = 0;
   logic [7:0] perAddr = 0;
   logic [31:0] perWrData = 0, perRdData;
   logic perRdValid, adcStart, adcDone, epValid, epReady;
   logic [1:0] adcSel, epPin;
   logic [11:0] adcResult, epSample;
   logic [23:0] epDest;
   int bad_count = 0, compares = 0;
   asr_sample_router dut_u (.*);
   asr_partner far_u (.*);
   initial forever #25 mclk = ~mclk;
   // destination picked for each pin
   function automatic logic [23:0] dst(input logic [1:0] p);
      dst = {20'h5_a3c0, 2'b00, p};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      perWrEn <= 1;
      perAddr <= a;
      perWrData <= d;
      @(posedge mclk);
      perWrEn <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      perRdEn <= 1;
      perAddr <= a;
      @(posedge mclk);
      perRdEn <= 0;
      #1 chk({31'b0, perRdValid}, 1);
      chk(perRdData, e);
   endtask
   // one sample clock edge, then check the delivered sample
   task automatic smp(input logic [1:0] p);
      int n;
      n = 0;
      @(posedge mclk);
      sampleClkPin <= 1;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (!(epValid === 1 && epReady === 1) && n < 60);
      chk({31'b0, n >= 60}, 32'h0000_0000);
      chk({8'h0, epDest}, {8'h0, dst(p)});
      chk({30'b0, epPin}, {30'b0, p});
      chk({20'b0, epSample}, {20'b0, p, 10'h2a5});
      @(posedge mclk);
      sampleClkPin <= 0;
      repeat (4) @(posedge mclk);
   endtask
   task automatic stop_test;
      $display("counts: compares=%0d mismatches=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge mclk);
      bad_count++;
      stop_test;
   end
   initial begin
      repeat (10) @(posedge mclk);
      sys_rst <= 0;
      for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0000_0000);
      rd(8'h20, 32'h0000_0031);
      rd(8'h10, 32'h0000_0000);
      $display("test reset values done");
      wr(8'h04, 32'hffff_ffff);
      rd(8'h04, 32'hffff_ff01);
      wr(8'h04, 32'h0000_0000);
      rd(8'h04, 32'h0000_0000);
      $display("test field access done");
      wr(8'h00, {dst(0), 8'h01});
      wr(8'h08, {dst(2), 8'h01});
      wr(8'h0c, {dst(3), 8'h00});
      rd(8'h08, {dst(2), 8'h01});
      smp(0);
      smp(2);
      smp(0);
      wr(8'h0c, {dst(3), 8'h01});
      smp(2);
      smp(3);
      rd(8'h20, 32'h0000_0031);
      $display("test routing done");
      // an edge while the sample is in flight is dropped and flags overrun
      @(posedge mclk);
      sampleClkPin <= 1;
      repeat (4) @(posedge mclk);
      sampleClkPin <= 0;
      repeat (2) @(posedge mclk);
      sampleClkPin <= 1;
      repeat (20) @(posedge mclk);
      rd(8'h20, 32'h0000_0003);
      wr(8'h20, 32'h0000_0003);
      rd(8'h20, 32'h0000_0001);
      // with the general enable off an edge starts nothing
      wr(8'h20, 32'h0000_0000);
      @(posedge mclk);
      sampleClkPin <= 0;
      repeat (4) @(posedge mclk);
      sampleClkPin <= 1;
      repeat (20) @(posedge mclk);
      sampleClkPin <= 0;
      rd(8'h20, 32'h0000_0000);
      $display("test overrun and enable done");
      stop_test;
   end
endmodule
`default_nettype wire

//--- hdl/asr_map.vh
// register offsets, field positions, reset values and sizes of the sample router
`ifndef ASR_MAP_VH
`define ASR_MAP_VH
// per-pin route control registers, one aligned word each
`define ASR_OFF_PIN0 8'h00
`define ASR_OFF_PIN1 8'h04
`define ASR_OFF_PIN2 8'h08
`define ASR_OFF_PIN3 8'h0c
// general converter control register
`define ASR_OFF_GEN 8'h20
// per-pin register fields
`define ASR_DEST_MSB 31
`define ASR_DEST_LSB 8
`define ASR_DEST_W 24
`define ASR_PIN_EN_BIT 0
`define ASR_PIN_RST_DEST 24'h00_0000
`define ASR_PIN_RST_EN 1'b0
// general control fields
`define ASR_GEN_EN_BIT 0
`define ASR_GEN_OVR_BIT 1
`define ASR_GEN_BUSY_BIT 2
`define ASR_GEN_LAST_LSB 4
`define ASR_GEN_RST_EN 1'b1
// sizes
`define ASR_SAMPLE_W 12
`define ASR_NUM_PINS 4
`define ASR_PIN_IDX_W 2
`endif

//--- hdl/asr_pin_reg.v
// one per-pin route control register: destination identifier and enable
`default_nettype none
module asr_pin_reg (
   input wire mclk, // peripheral clock
   input wire sys_rst, // synchronous reset, active high
   input wire wrEn, // write strobe for this register
   input wire [31:0] wrData, // write data word
   output wire [23:0] dest, // destination node and endpoint identifier
   output wire en, // pin enable
   output wire [31:0] rdData // read-back word
);
`include "asr_map.vh"
   reg [23:0] dest_ff; // stored destination
   reg en_ff; // stored enable
   // store destination and enable; reserved bits are not stored
   always @(posedge mclk) begin
      if (sys_rst) begin
         dest_ff <= `ASR_PIN_RST_DEST;
         en_ff <= `ASR_PIN_RST_EN;
      end else if (wrEn) begin
         dest_ff <= wrData[`ASR_DEST_MSB:`ASR_DEST_LSB];
         en_ff <= wrData[`ASR_PIN_EN_BIT];
      end
   end
   assign dest = dest_ff;
   assign en = en_ff;
   // reserved bits 7:1 read as zero
   assign rdData = {dest_ff, 7'h00, en_ff};
endmodule
`default_nettype wire

//--- hdl/asr_sample_router.v
// sample router: steps through enabled inputs on sample clock edges and routes results
// Functional notes
// - each sample is a 12-bit result
// - each sample-clock rising edge taken in idle with the general enable on converts next enabled pin
// - result goes to that pin's configured endpoint
// - per-pin registers at 0x00, 0x04, 0x08, 0x0C
// - general control register at 0x20
// - bits 31:8 destination, reset zero; 7:1 reserved
// - bit 0 enables the pin, reset off
`default_nettype none
module asr_sample_router (
   input wire mclk, // peripheral clock, 20 MHz
   input wire sys_rst, // synchronous reset, active high
   input wire perWrEn, // peripheral word write strobe
   input wire perRdEn, // peripheral word read strobe
   input wire [7:0] perAddr, // peripheral byte address
   input wire [31:0] perWrData, // peripheral write word
   output reg [31:0] perRdData, // peripheral read word, registered
   output reg perRdValid, // read data valid pulse
   input wire sampleClkPin, // sample clock from the i/o port, asynchronous
   output reg adcStart, // start conversion pulse
   output reg [1:0] adcSel, // selected analog input
   input wire adcDone, // conversion finished pulse
   input wire [11:0] adcResult, // conversion result
   output wire epValid, // sample offered to the endpoint
   input wire epReady, // endpoint takes the sample
   output reg [23:0] epDest, // destination node and endpoint identifier
   output reg [1:0] epPin, // input pin the sample came from
   output reg [11:0] epSample // converted sample value
);
`include "asr_map.vh"
   localparam [1:0] ST_IDLE = 2'b00; // waiting for a sample edge
   localparam [1:0] ST_CONV = 2'b01; // converter busy
   localparam [1:0] ST_SEND = 2'b10; // offering result to endpoint

   reg syncA_ff; // first synchroniser stage
   reg syncB_ff; // second synchroniser stage
   reg syncPrev_ff; // previous synchronised level
   reg [1:0] state_ff; // router state
   reg [1:0] nxt_state; // next router state
   reg [1:0] lastPin_ff; // pin converted most recently
   reg globEn_ff; // general enable
   reg ovr_ff; // sticky: sample edge came while busy
   reg [1:0] nxtPick; // next enabled pin
   reg nxtFound; // at least one pin enabled
   reg [1:0] cand; // candidate pin in the search
   integer i; // search index
   wire [3:0] pinEn; // per-pin enables
   wire [95:0] pinDest; // per-pin destinations, packed
   wire [127:0] pinRd; // per-pin read words, packed
   wire sampleEdge; // rising edge of the sample clock
   wire genHit; // access hits the general register
   wire [31:0] genRd; // general register read word

   // two-flop synchroniser and edge detect on the sample clock pin
   // only the second stage feeds logic, so a metastable first stage stays hidden
   // stages reset low, the idle level of the pin, so no false edge follows reset
   always @(posedge mclk) begin
      if (sys_rst) begin
         syncA_ff <= 1'b0;
         syncB_ff <= 1'b0;
         syncPrev_ff <= 1'b0;
      end else begin
         syncA_ff <= sampleClkPin;
         syncB_ff <= syncA_ff;
         syncPrev_ff <= syncB_ff;
      end
   end
   assign sampleEdge = syncB_ff & ~syncPrev_ff;

   // per-pin registers, one word each
   genvar g;
   generate
      for (g = 0; g < `ASR_NUM_PINS; g = g + 1) begin : gPin
         wire hit;
         // word decode: upper nibble zero, index in bits 3:2, aligned
         // unaligned or unmapped addresses hit no register, so writes there are lost
         assign hit = (perAddr[7:4] == 4'h0) && (perAddr[3:2] == g)
            && (perAddr[1:0] == 2'b00);
         asr_pin_reg uPin (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .wrEn(perWrEn & hit),
            .wrData(perWrData),
            .dest(pinDest[g*24 +: 24]),
            .en(pinEn[g]),
            .rdData(pinRd[g*32 +: 32])
         );
      end
   endgenerate

   // general control register decode
   // the general register is matched on the whole byte address
   assign genHit = (perAddr == `ASR_OFF_GEN);
   assign genRd = {26'h000_0000, lastPin_ff, 1'b0, (state_ff != ST_IDLE), ovr_ff, globEn_ff};

   // general enable and sticky overrun flag; a new overrun wins over the clear
   // an edge that lands while converting or sending is dropped, and the
   // flag lets software see that a sample was lost
   always @(posedge mclk) begin
      if (sys_rst) begin
         globEn_ff <= `ASR_GEN_RST_EN;
         ovr_ff <= 1'b0;
      end else begin
         if (perWrEn && genHit) begin
            globEn_ff <= perWrData[`ASR_GEN_EN_BIT];
         end
         // set is tested first so it beats a clear in the same cycle
         if (sampleEdge && (state_ff != ST_IDLE)) begin
            ovr_ff <= 1'b1;
         end else if (perWrEn && genHit && perWrData[`ASR_GEN_OVR_BIT]) begin
            ovr_ff <= 1'b0; // write one to clear
         end
      end
   end

   // registered read port; unmapped addresses read as zero
   // the word holds until the next read, so a slow master may take it late
   always @(posedge mclk) begin
      if (sys_rst) begin
         perRdData <= 32'h0000_0000;
         perRdValid <= 1'b0;
      end else begin
         perRdValid <= perRdEn;
         if (perRdEn) begin
            if (genHit) begin
               perRdData <= genRd;
            end else if (perAddr == `ASR_OFF_PIN0) begin
               perRdData <= pinRd[31:0];
            end else if (perAddr == `ASR_OFF_PIN1) begin
               perRdData <= pinRd[63:32];
            end else if (perAddr == `ASR_OFF_PIN2) begin
               perRdData <= pinRd[95:64];
            end else if (perAddr == `ASR_OFF_PIN3) begin
               perRdData <= pinRd[127:96];
            end else begin
               // no register here: answer with zero
               perRdData <= 32'h0000_0000;
            end
         end
      end
   end

   // round-robin search for the next enabled pin after the last one
   // a pin found at distance four is the last pin itself, so a single
   // enabled pin is converted again on every edge
   always @* begin
      nxtFound = 1'b0;
      nxtPick = lastPin_ff;
      cand = lastPin_ff;
      // descending so the nearest enabled successor is kept last
      for (i = `ASR_NUM_PINS; i >= 1; i = i - 1) begin
         cand = lastPin_ff + i[1:0];
         if (pinEn[cand]) begin
            nxtFound = 1'b1;
            nxtPick = cand;
         end
      end
   end

   // router state transitions
   // an edge with no pin enabled or the general enable off is ignored
   // one conversion at a time; edges are taken only in the idle state
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (sampleEdge && globEn_ff && nxtFound) begin
               nxt_state = ST_CONV;
            end
         end
         ST_CONV: begin
            if (adcDone) begin
               nxt_state = ST_SEND;
            end
         end
         ST_SEND: begin
            if (epReady) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // state, selection, start pulse and captured result
   // the destination is read when the result arrives, so a route change
   // made during a conversion already applies to that sample
   always @(posedge mclk) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         lastPin_ff <= 2'b11;
         adcStart <= 1'b0;
         adcSel <= 2'b00;
         epDest <= 24'h00_0000;
         epPin <= 2'b00;
         epSample <= 12'h000;
      end else begin
         state_ff <= nxt_state;
         adcStart <= 1'b0;
         if ((state_ff == ST_IDLE) && (nxt_state == ST_CONV)) begin
            adcStart <= 1'b1;
            adcSel <= nxtPick;
            lastPin_ff <= nxtPick;
         end
         // capture the result and its route in the cycle the converter is done
         if ((state_ff == ST_CONV) && adcDone) begin
            epSample <= adcResult;
            epPin <= adcSel;
            epDest <= pinDest[adcSel*24 +: 24];
         end
      end
   end

   // sample is offered while in the send state
   // the offer and its data hold until the endpoint takes them
   assign epValid = (state_ff == ST_SEND);
endmodule
`default_nettype wire
